// [pkg/plipd_pkg.sv]
// Constants and carrier types for the tuner synthesizer front end.
// Assumes a single 25 MHz clock domain.
package plipd_pkg;

    // ----------------------------------------------------------------
    // Control word layout
    // ----------------------------------------------------------------
    localparam int        CW_SRC_POS     = 2;
    localparam int        CW_BAND_POS    = 0;
    localparam logic [3:0] CW_RESET_VAL  = 4'h0;
    localparam logic [1:0] SRC_STOP      = 2'h0;
    localparam logic [1:0] SRC_FM        = 2'h1;
    localparam logic [1:0] SRC_AM        = 2'h2;
    localparam logic [1:0] BAND_MW_LW    = 2'h3;
    localparam logic [15:0] DIV_N_RESET  = 16'h0001;
    localparam logic [15:0] REF_RESET    = 16'h03E8;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int        CLK_MHZ        = 25;
    localparam int        MCYC_US        = 40;
    localparam logic [10:0] MCYC_CYCLES  = 11'(CLK_MHZ * MCYC_US);

    typedef enum logic [1:0] {
        PLIPD_STOPPED = 2'b00,
        PLIPD_RUN     = 2'b01
    } plipd_state_t;

    typedef enum logic [1:0] {
        PLIPD_CP_Z    = 2'b00,
        PLIPD_CP_HIGH = 2'b01,
        PLIPD_CP_LOW  = 2'b10
    } plipd_cp_t;

    typedef struct packed {
        logic       write;
        logic [3:0] word;
    } plipd_cw_t;

    typedef struct packed {
        logic o;
        logic oe;
    } plipd_pin_t;

endpackage : plipd_pkg

// [src/plipd_top.sv]
// Tuner synthesizer front end: input select, divider, comparator, charge pump, reset.
// Assumes VCO inputs are already squared up and reference period is a count of mclk_i.
// Notes on behaviour
// - External reset and power-on reset both drive the same system reset.
// - Battery high starts the oscillator; its level is readable by software.
// - FM input enabled only when control word selects FM source.
// - AM input routed when selected; low two bits pick band, 11 is 0.5-10 MHz.
// - Both inputs disabled in backup, halt, reset and synthesizer stop.
// - Charge pump high when divided above reference, low when below, else Z.
// - Charge pump is high impedance in backup, halt, reset and stop.
`timescale 1ns/100ps
module plipd_top
    import plipd_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        system_reset_in_n_i,
    input  wire logic        por_n_i,
    input  wire logic        battery_presence_in_i,
    input  wire logic        backup_mode_i,
    input  wire logic        halt_mode_i,
    input  wire plipd_cw_t   cw_i,
    input  wire logic [15:0] div_n_i,
    input  wire logic [15:0] ref_period_i,
    input  wire logic        fm_vco_input_i,
    input  wire logic        am_vco_input_i,
    output logic             sys_reset_o,
    output logic             osc_enable_o,
    output logic             battery_level_o,
    output logic             fm_enable_o,
    output logic             am_enable_o,
    output logic [1:0]       am_band_o,
    output logic             charge_pump_out_o,
    output logic             charge_pump_out_oe_o
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_reg, por_sync_reg, battery_presence_in_sync_reg, fm_sync_reg, am_sync_reg;
    logic [1:0] rst_sync_next, por_sync_next, battery_presence_in_sync_next, fm_sync_next, am_sync_next;
    logic       vco_prev_reg, vco_prev_next;

    always_comb begin
        rst_sync_next  = {rst_sync_reg[0], system_reset_in_n_i};
        por_sync_next  = {por_sync_reg[0], por_n_i};
        battery_presence_in_sync_next = {battery_presence_in_sync_reg[0], battery_presence_in_i};
        fm_sync_next   = {fm_sync_reg[0], fm_vco_input_i};
        am_sync_next   = {am_sync_reg[0], am_vco_input_i};
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_reg  <= 2'h0;
            por_sync_reg  <= 2'h0;
            battery_presence_in_sync_reg <= 2'h0;
            fm_sync_reg   <= 2'h0;
            am_sync_reg   <= 2'h0;
        end else begin
            rst_sync_reg  <= rst_sync_next;
            por_sync_reg  <= por_sync_next;
            battery_presence_in_sync_reg <= battery_presence_in_sync_next;
            fm_sync_reg   <= fm_sync_next;
            am_sync_reg   <= am_sync_next;
        end
    end

    // ----------------------------------------------------------------
    // System reset qualification
    // ----------------------------------------------------------------
    logic [10:0] low_cnt_reg, low_cnt_next;
    logic        sys_rst_reg, sys_rst_next;
    logic        ext_rst;

    always_comb begin
        low_cnt_next = low_cnt_reg;
        if (rst_sync_reg[1]) begin
            low_cnt_next = 11'h000;
        end else if (low_cnt_reg != MCYC_CYCLES) begin
            low_cnt_next = low_cnt_reg + 11'h001;
        end
        ext_rst      = (low_cnt_next == MCYC_CYCLES);
        sys_rst_next = ext_rst || !por_sync_reg[1];
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_cnt_reg <= 11'h000;
            sys_rst_reg <= 1'b1;
        end else begin
            low_cnt_reg <= low_cnt_next;
            sys_rst_reg <= sys_rst_next;
        end
    end

    // ----------------------------------------------------------------
    // Control word and run state
    // ----------------------------------------------------------------
    plipd_state_t state_reg, state_next;
    logic [3:0]   cw_reg, cw_next;
    logic         gate_off;

    function automatic logic [1:0] cw_src(input logic [3:0] w);
        cw_src = w[CW_SRC_POS +: 2];
    endfunction : cw_src

    always_comb begin
        cw_next    = cw_reg;
        state_next = state_reg;
        gate_off   = sys_rst_reg || backup_mode_i || halt_mode_i;
        if (sys_rst_reg) begin
            cw_next    = CW_RESET_VAL;
            state_next = PLIPD_STOPPED;
        end else if (cw_i.write) begin
            cw_next = cw_i.word;
            case (cw_src(cw_i.word))
                SRC_FM, SRC_AM: state_next = PLIPD_RUN;
                default:        state_next = PLIPD_STOPPED;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cw_reg    <= CW_RESET_VAL;
            state_reg <= PLIPD_STOPPED;
        end else begin
            cw_reg    <= cw_next;
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Input enables, divider and comparator
    // ----------------------------------------------------------------
    logic        fm_en_next, am_en_next, fm_en_reg, am_en_reg;
    logic [1:0]  band_reg, band_next;
    logic [15:0] div_cnt_reg, div_cnt_next, ref_cnt_reg, ref_cnt_next;
    logic [15:0] quot_reg, quot_next;
    logic        vco_bit, vco_rise, active;
    plipd_cp_t   cp_reg, cp_next;
    logic        osc_reg, osc_next, battery_presence_in_reg, battery_presence_in_next;
    plipd_pin_t  pin_reg, pin_next;

    always_comb begin
        active     = (state_reg == PLIPD_RUN) && !gate_off;
        fm_en_next = active && (cw_src(cw_reg) == SRC_FM);
        am_en_next = active && (cw_src(cw_reg) == SRC_AM);
        band_next  = cw_reg[CW_BAND_POS +: 2];
        vco_bit    = (fm_en_reg && fm_sync_reg[1]) || (am_en_reg && am_sync_reg[1]);
        vco_rise   = vco_bit && !vco_prev_reg;
        vco_prev_next = vco_bit;
        div_cnt_next  = div_cnt_reg;
        quot_next     = quot_reg;
        ref_cnt_next  = ref_cnt_reg + 16'h0001;
        cp_next       = cp_reg;
        if (!active) begin
            div_cnt_next = 16'h0000;
            quot_next    = 16'h0000;
            ref_cnt_next = 16'h0000;
            cp_next      = PLIPD_CP_Z;
        end else begin
            if (vco_rise) begin
                if (div_cnt_reg + 16'h0001 >= div_n_i) begin
                    div_cnt_next = 16'h0000;
                    quot_next    = quot_reg + 16'h0001;
                end else begin
                    div_cnt_next = div_cnt_reg + 16'h0001;
                end
            end
            if (ref_cnt_reg + 16'h0001 >= ref_period_i) begin
                ref_cnt_next = 16'h0000;
                quot_next    = 16'h0000;
                if (quot_reg > 16'h0001) begin
                    cp_next = PLIPD_CP_HIGH;
                end else if (quot_reg < 16'h0001) begin
                    cp_next = PLIPD_CP_LOW;
                end else begin
                    cp_next = PLIPD_CP_Z;
                end
            end
        end
        osc_next    = battery_presence_in_sync_reg[1];
        battery_presence_in_next   = osc_reg;
        pin_next.o  = (cp_next == PLIPD_CP_HIGH);
        pin_next.oe = (cp_next != PLIPD_CP_Z);
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fm_en_reg    <= 1'b0;
            am_en_reg    <= 1'b0;
            band_reg     <= 2'h0;
            div_cnt_reg  <= 16'h0000;
            ref_cnt_reg  <= 16'h0000;
            quot_reg     <= 16'h0000;
            vco_prev_reg <= 1'b0;
            cp_reg       <= PLIPD_CP_Z;
            osc_reg      <= 1'b0;
            battery_presence_in_reg     <= 1'b0;
            pin_reg      <= '0;
        end else begin
            fm_en_reg    <= fm_en_next;
            am_en_reg    <= am_en_next;
            band_reg     <= band_next;
            div_cnt_reg  <= div_cnt_next;
            ref_cnt_reg  <= ref_cnt_next;
            quot_reg     <= quot_next;
            vco_prev_reg <= vco_prev_next;
            cp_reg       <= cp_next;
            osc_reg      <= osc_next;
            battery_presence_in_reg     <= battery_presence_in_next;
            pin_reg      <= pin_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sys_reset_o          = sys_rst_reg;
    assign osc_enable_o         = osc_reg;
    assign battery_level_o      = battery_presence_in_reg;
    assign fm_enable_o          = fm_en_reg;
    assign am_enable_o          = am_en_reg;
    assign am_band_o            = band_reg;
    assign charge_pump_out_o    = pin_reg.o;
    assign charge_pump_out_oe_o = pin_reg.oe;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_reset_or_merge: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        !por_sync_reg[1] |=> sys_rst_reg) else $error("por did not reset");
    chk_ext_reset_len: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (low_cnt_reg == MCYC_CYCLES - 11'h001) && !rst_sync_reg[1] |=> sys_rst_reg)
        else $error("ext reset not taken");
    chk_battery_presence_in_follow: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        battery_presence_in_sync_reg[1] |=> osc_enable_o ##1 battery_level_o)
        else $error("battery level lost");
    chk_fm_select: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        fm_enable_o |-> $past(cw_src(cw_reg)) == SRC_FM) else $error("fm wrong");
    chk_am_band: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        am_enable_o |-> am_band_o == $past(cw_reg[1:0])) else $error("am band");
    chk_inputs_gated: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (halt_mode_i || backup_mode_i || sys_rst_reg) |=> !fm_enable_o && !am_enable_o)
        else $error("inputs not gated");
    chk_pump_z_gated: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (halt_mode_i || backup_mode_i || sys_rst_reg || state_reg == PLIPD_STOPPED)
        |=> !charge_pump_out_oe_o)
        else $error("pump not z");
    chk_pump_high: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        active && (ref_cnt_reg + 16'h0001 >= ref_period_i) && quot_reg > 16'h0001
        |=> charge_pump_out_oe_o && charge_pump_out_o) else $error("pump high");
    chk_stop_after_rst: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        sys_rst_reg |=> state_reg == PLIPD_STOPPED) else $error("not stopped");

endmodule : plipd_top

// [tb/plipd_vco_model.sv]
// Far side of the synthesizer: square-wave VCO and loop-filter integrator.
// Assumes the bench sets the VCO half period in ns; zero stops the VCO.
`timescale 1ns/100ps
module plipd_vco_model (
    input  wire logic        cp_i,
    input  wire logic        cp_oe_i,
    input  wire logic [15:0] half_ns_i,
    output logic             vco_o,
    output logic [15:0]      tune_o
);
    // ----------------------------------------------------------------
    // Oscillator and loop filter
    // ----------------------------------------------------------------
    initial begin
        vco_o  = 1'b0;
        tune_o = 16'h8000;
    end

    always begin
        if (half_ns_i == 16'h0000) begin
            #40;
        end else begin
            #(half_ns_i);
            vco_o = ~vco_o;
        end
    end

    // Pumps up on high, down on low, holds while released
    always #40 if (cp_oe_i) tune_o = cp_i ? tune_o + 16'h0001 : tune_o - 16'h0001;
endmodule : plipd_vco_model

// [tb/tb.sv]
// Self-checking bench for the synthesizer front end.
// Assumes the VCO model stands on both oscillator inputs.
`timescale 1ns/100ps
module tb;
    import plipd_pkg::*;
    logic        mclk_i, resetn_i, ext_rst_n, por_n, battery_presence_in, backup, halt;
    logic        fm_vco, am_vco, sys_rst, osc_en, battery_presence_in_lvl, fm_en, am_en, cp_o, cp_oe;
    logic [1:0]  band;
    logic [15:0] div_n, ref_per, fm_half, am_half, fm_tune, am_tune;
    plipd_cw_t   cw;
    int          fail_count, n_tests;

    plipd_top u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .system_reset_in_n_i(ext_rst_n),
        .por_n_i(por_n), .battery_presence_in_i(battery_presence_in), .backup_mode_i(backup),
        .halt_mode_i(halt), .cw_i(cw), .div_n_i(div_n), .ref_period_i(ref_per),
        .fm_vco_input_i(fm_vco), .am_vco_input_i(am_vco), .sys_reset_o(sys_rst),
        .osc_enable_o(osc_en), .battery_level_o(battery_presence_in_lvl), .fm_enable_o(fm_en),
        .am_enable_o(am_en), .am_band_o(band), .charge_pump_out_o(cp_o),
        .charge_pump_out_oe_o(cp_oe));
    plipd_vco_model u_fm (.cp_i(cp_o), .cp_oe_i(cp_oe), .half_ns_i(fm_half),
        .vco_o(fm_vco), .tune_o(fm_tune));
    plipd_vco_model u_am (.cp_i(cp_o), .cp_oe_i(cp_oe), .half_ns_i(am_half),
        .vco_o(am_vco), .tune_o(am_tune));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick

    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task results;
        $display("mismatches %0d comparisons %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    task wcw(input logic [3:0] w);
        cw = '{1'b1, w};
        tick(1);
        cw.write = 1'b0;
        tick(2);
    endtask : wcw

    task wait_rst(input logic lvl);
        for (int i = 0; i < 2000 && sys_rst !== lvl; i++) tick(1);
        chk("sys_reset", sys_rst, lvl);
        if (sys_rst !== lvl) results();
    endtask : wait_rst

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    initial begin
        resetn_i = 1'b0; ext_rst_n = 1'b1; por_n = 1'b1; battery_presence_in = 1'b0;
        backup = 1'b0; halt = 1'b0; cw = '0; div_n = 16'h000A; ref_per = 16'h0190;
        fm_half = 16'h0050; am_half = 16'h0050; fail_count = 0; n_tests = 0;
        tick(2);
        chk("sys_reset", sys_rst, 1'b1);
        chk("cp_oe", cp_oe, 1'b0);
        chk("fm_en", fm_en, 1'b0);
        tick(2);
        resetn_i = 1'b1;
        wait_rst(1'b0);
        chk("fm_en", fm_en, 1'b0);
        chk("am_en", am_en, 1'b0);
        battery_presence_in = 1'b1;
        tick(3);
        chk("osc_en", osc_en, 1'b1);
        chk("battery_presence_in_lvl", battery_presence_in_lvl, 1'b0);
        tick(1);
        chk("battery_presence_in_lvl", battery_presence_in_lvl, 1'b1);
        battery_presence_in = 1'b0;
        tick(4);
        chk("osc_en", osc_en, 1'b0);
        chk("battery_presence_in_lvl", battery_presence_in_lvl, 1'b0);
        for (int s = 0; s < 4; s++) begin
            wcw({s[1:0], 2'h3});
            chk("fm_en", fm_en, s == 1);
            chk("am_en", am_en, s == 2);
            if (s == 3) chk("cp_oe", cp_oe, 1'b0);
        end
        wcw(4'hB);
        chk("band", band, BAND_MW_LW);
        tick(1000);
        chk("cp_oe", cp_oe, 1'b1);
        chk("cp_high", cp_o, 1'b1);
        chk("am_tune", {15'h0000, am_tune > 16'h8000}, 16'h0001);
        div_n = 16'hFFFF;
        tick(1000);
        chk("cp_oe", cp_oe, 1'b1);
        chk("cp_low", cp_o, 1'b0);
        halt = 1'b1;
        tick(2);
        chk("am_en", am_en, 1'b0);
        chk("cp_oe", cp_oe, 1'b0);
        halt = 1'b0;
        wcw(4'h4);
        chk("fm_en", fm_en, 1'b1);
        backup = 1'b1;
        tick(2);
        chk("fm_en", fm_en, 1'b0);
        chk("cp_oe", cp_oe, 1'b0);
        backup = 1'b0;
        ext_rst_n = 1'b0;
        tick(500);
        chk("sys_reset", sys_rst, 1'b0);
        ext_rst_n = 1'b1;
        tick(3);
        wcw(4'hB);
        ext_rst_n = 1'b0;
        wait_rst(1'b1);
        tick(1);
        chk("am_en", am_en, 1'b0);
        chk("cp_oe", cp_oe, 1'b0);
        ext_rst_n = 1'b1;
        wait_rst(1'b0);
        chk("am_en", am_en, 1'b0);
        por_n = 1'b0;
        wait_rst(1'b1);
        por_n = 1'b1;
        wait_rst(1'b0);
        results();
    end
endmodule : tb
